// ===== hw/vvc_map.svh
// Register map, field positions, reset values and timing of the classifier
`ifndef VVC_MAP_SVH
`define VVC_MAP_SVH
// ========================================
// Register offsets
`define VVC_REG_CTRL    8'h00
`define VVC_REG_VID     8'h04
`define VVC_REG_AGING   8'h08
`define VVC_REG_PORT_EN 8'h0c
`define VVC_REG_COS     8'h10
`define VVC_REG_STATUS  8'h14
`define VVC_REG_MGMT    8'h18
`define VVC_REG_MVR     8'h1c
`define VVC_BLK_PORT_DEFAULT_VLAN_ID    3'h2
`define VVC_BLK_OUI     3'h4
`define VVC_BLK_DESC    3'h6
// ========================================
// Field positions
`define VVC_CTRL_EN     0
`define VVC_CTRL_RW     1
`define VVC_CTRL_PRIO   6:4
`define VVC_OUI_VALID   31
`define VVC_STAT_CONF   0
`define VVC_STAT_MEMB   15:8
// ========================================
// Reset values and limits
`define VVC_VID_RST     12'h001
`define VVC_PRIO_RST    3'h6
`define VVC_AGING_RST   17'h005a0
`define VVC_AGING_MIN   17'h0001e
`define VVC_AGING_MAX   17'h10000
`define VVC_RESP_OK     2'h0
`define VVC_RESP_ERR    2'h2
// ========================================
// Timing
`define VVC_CLK_NS      64'd8
`define VVC_MINUTE_NS   64'd60000000000
`endif

// ===== hw/vvc_pkg.sv
// Types shared by the voice VLAN classifier
`default_nettype none
package vvc_pkg;
  // ========================================
  // Per-port priority handling for voice frames
  typedef enum logic [1:0] {
    VVC_COS_FOLLOW = 2'b00,
    VVC_COS_KEEP   = 2'b01,
    VVC_COS_FORCE  = 2'b10
  } vvc_cos_t;
  // ========================================
  // Complete block state
  typedef struct packed {
    logic              glb_en;
    logic              rw_en;
    logic [2:0]        prio;
    logic [11:0]       vid;
    logic [16:0]       aging;
    logic [7:0]        port_en;
    logic [7:0][1:0]   cos_mode;
    logic [11:0]       mgmt_vid;
    logic [11:0]       multicast_registration_vlan_id;
    logic [7:0][11:0]  port_default_vlan_id;
    logic [7:0]        oui_vld;
    logic [7:0][23:0]  oui;
    logic [7:0][31:0]  desc;
    logic [32:0]       tick_cnt;
    logic [7:0][16:0]  age_cnt;
    logic [7:0]        member;
    logic              conflict;
    logic              aw_got;
    logic [7:0]        aw_addr;
    logic              w_got;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic              out_valid;
    logic [2:0]        out_port;
    logic [11:0]       out_vid;
    logic [2:0]        out_pcp;
    logic              out_voice;
  } vvc_state_t;
endpackage
`default_nettype wire

// ===== hw/vvc_classifier.sv
// Voice VLAN ingress classifier with AXI4-Lite configuration
`timescale 1ns/1ps
`default_nettype none
`include "vvc_map.svh"

module vvc_classifier #(
  parameter longint MINUTE_CYCLES = `VVC_MINUTE_NS / `VVC_CLK_NS
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Ingress frame headers
  input  wire logic        in_valid,
  input  wire logic [2:0]  in_port,
  input  wire logic [47:0] in_src_mac,
  input  wire logic [11:0] in_vid,
  input  wire logic [2:0]  in_pcp,
  // Classified frame headers
  output logic             out_valid,
  output logic [2:0]       out_port,
  output logic [11:0]      out_vid,
  output logic [2:0]       out_pcp,
  output logic             out_voice,
  // Port state
  output logic [7:0]       voice_member,
  output logic             vid_conflict
);
  localparam logic [32:0] TICK_LAST = 33'(MINUTE_CYCLES - 64'd1);

  vvc_pkg::vvc_state_t s;
  vvc_pkg::vvc_state_t next_s;

  // ========================================
  // Prefix match and identifier clash
  logic [7:0] oui_hit;
  logic [7:0] port_default_vlan_id_eq;
  logic       hit;
  logic       voice;
  logic       do_rw;
  logic [1:0] mode;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_entry
      assign oui_hit[gi] = s.oui_vld[gi] &&
                           (s.oui[gi] == in_src_mac[47:24]);
      assign port_default_vlan_id_eq[gi] = (s.port_default_vlan_id[gi] == s.vid);
    end
  endgenerate

  assign hit   = |oui_hit;
  // Port is looked up per frame, so any enabled port works
  assign voice = s.glb_en && s.port_en[in_port] && hit;
  assign mode  = s.cos_mode[in_port];
  assign do_rw = (mode == vvc_pkg::VVC_COS_FORCE) ||
                 ((mode == vvc_pkg::VVC_COS_FOLLOW) && s.rw_en);

  // ========================================
  // Register readback
  function automatic logic [31:0] readback(input vvc_pkg::vvc_state_t st,
                                           input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (a)
      `VVC_REG_CTRL: begin
        d[`VVC_CTRL_EN]   = st.glb_en;
        d[`VVC_CTRL_RW]   = st.rw_en;
        d[`VVC_CTRL_PRIO] = st.prio;
      end
      `VVC_REG_VID:     d[11:0] = st.glb_en ? st.vid : 12'h000;
      `VVC_REG_AGING:   d[16:0] = st.aging;
      `VVC_REG_PORT_EN: d[7:0]  = st.port_en;
      `VVC_REG_COS:     d[15:0] = st.cos_mode;
      `VVC_REG_STATUS: begin
        d[`VVC_STAT_CONF] = st.conflict;
        d[`VVC_STAT_MEMB] = st.member;
      end
      `VVC_REG_MGMT:    d[11:0] = st.mgmt_vid;
      `VVC_REG_MVR:     d[11:0] = st.multicast_registration_vlan_id;
      default: begin
        case (a[7:5])
          `VVC_BLK_PORT_DEFAULT_VLAN_ID: d[11:0] = st.port_default_vlan_id[a[4:2]];
          `VVC_BLK_OUI: begin
            d[23:0]           = st.oui[a[4:2]];
            d[`VVC_OUI_VALID] = st.oui_vld[a[4:2]];
          end
          `VVC_BLK_DESC: d = st.desc[a[4:2]];
          default: d = 32'h0000_0000;
        endcase
      end
    endcase
    return d;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return (a[7:5] == 3'h0) || (a[7:5] == `VVC_BLK_PORT_DEFAULT_VLAN_ID) ||
           (a[7:5] == `VVC_BLK_OUI) || (a[7:5] == `VVC_BLK_DESC);
  endfunction

  // ========================================
  // Next state
  logic [31:0] old_w;
  logic [31:0] wv;
  logic        tick;

  always_comb begin
    next_s = s;
    old_w  = readback(s, s.aw_addr);
    if (s.aw_addr == `VVC_REG_VID) begin
      old_w[11:0] = s.vid;
    end
    for (int b = 0; b < 4; b++) begin
      wv[b*8 +: 8] = s.wstrb[b] ? s.wdata[b*8 +: 8] : old_w[b*8 +: 8];
    end
    // Classified header, one cycle behind the input
    next_s.out_valid = in_valid;
    next_s.out_port  = in_port;
    next_s.out_voice = in_valid && voice;
    next_s.out_vid   = voice ? s.vid : in_vid;
    next_s.out_pcp   = (voice && do_rw) ? s.prio : in_pcp;
    // Minute tick and per-port aging
    tick = (s.tick_cnt == TICK_LAST);
    next_s.tick_cnt = tick ? 33'h0_0000_0000 : s.tick_cnt + 33'h0_0000_0001;
    for (int p = 0; p < 8; p++) begin
      if (!s.glb_en || !s.port_en[p]) begin
        next_s.age_cnt[p] = 17'h00000;
      end else if (in_valid && voice && (in_port == 3'(p))) begin
        next_s.age_cnt[p] = s.aging;
      end else if (tick && (s.age_cnt[p] != 17'h00000)) begin
        next_s.age_cnt[p] = s.age_cnt[p] - 17'h00001;
      end
      next_s.member[p] = (next_s.age_cnt[p] != 17'h00000);
    end
    next_s.conflict = (|port_default_vlan_id_eq) || (s.vid == s.mgmt_vid) ||
                      (s.vid == s.multicast_registration_vlan_id);
    // Write channel
    if (s.awready && s_axi_awvalid) begin
      next_s.aw_got  = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (s.wready && s_axi_wvalid) begin
      next_s.w_got = 1'b1;
      next_s.wdata = s_axi_wdata;
      next_s.wstrb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.aw_got && s.w_got && !s.bvalid) begin
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = mapped(s.aw_addr) ? `VVC_RESP_OK : `VVC_RESP_ERR;
      case (s.aw_addr)
        `VVC_REG_CTRL: begin
          next_s.glb_en = wv[`VVC_CTRL_EN];
          next_s.rw_en  = wv[`VVC_CTRL_RW];
          next_s.prio   = wv[`VVC_CTRL_PRIO];
        end
        `VVC_REG_VID: begin
          if (wv[11:0] != 12'h000) begin
            next_s.vid = wv[11:0];
          end else begin
            next_s.bresp = `VVC_RESP_ERR;
          end
        end
        `VVC_REG_AGING: begin
          if ((wv[16:0] >= `VVC_AGING_MIN) &&
              (wv[16:0] <= `VVC_AGING_MAX)) begin
            next_s.aging = wv[16:0];
          end else begin
            next_s.bresp = `VVC_RESP_ERR;
          end
        end
        `VVC_REG_PORT_EN: next_s.port_en  = wv[7:0];
        `VVC_REG_COS:     next_s.cos_mode = wv[15:0];
        `VVC_REG_MGMT:    next_s.mgmt_vid = wv[11:0];
        `VVC_REG_MVR:     next_s.multicast_registration_vlan_id  = wv[11:0];
        default: begin
          case (s.aw_addr[7:5])
            `VVC_BLK_PORT_DEFAULT_VLAN_ID: next_s.port_default_vlan_id[s.aw_addr[4:2]] = wv[11:0];
            `VVC_BLK_OUI: begin
              next_s.oui[s.aw_addr[4:2]]     = wv[23:0];
              next_s.oui_vld[s.aw_addr[4:2]] = wv[`VVC_OUI_VALID];
            end
            `VVC_BLK_DESC: next_s.desc[s.aw_addr[4:2]] = wv;
            default: next_s.bresp = `VVC_RESP_ERR;
          endcase
        end
      endcase
    end
    next_s.awready = !next_s.aw_got && !next_s.bvalid;
    next_s.wready  = !next_s.w_got && !next_s.bvalid;
    // Read channel
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (s.arready && s_axi_arvalid) begin
      next_s.rvalid = 1'b1;
      next_s.rdata  = readback(s, s_axi_araddr);
      next_s.rresp  = mapped(s_axi_araddr) ? `VVC_RESP_OK : `VVC_RESP_ERR;
    end
    next_s.arready = !next_s.rvalid;
  end

  // ========================================
  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s         <= '0;
      s.vid     <= `VVC_VID_RST;
      s.prio    <= `VVC_PRIO_RST;
      s.aging   <= `VVC_AGING_RST;
      s.awready <= 1'b1;
      s.wready  <= 1'b1;
      s.arready <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ========================================
  // Outputs
  assign s_axi_awready = s.awready;
  assign s_axi_wready  = s.wready;
  assign s_axi_bresp   = s.bresp;
  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_arready = s.arready;
  assign s_axi_rdata   = s.rdata;
  assign s_axi_rresp   = s.rresp;
  assign s_axi_rvalid  = s.rvalid;
  assign out_valid     = s.out_valid;
  assign out_port      = s.out_port;
  assign out_vid       = s.out_vid;
  assign out_pcp       = s.out_pcp;
  assign out_voice     = s.out_voice;
  assign voice_member  = s.member;
  assign vid_conflict  = s.conflict;

  // ========================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_VOICE_VID: assert property (
    (in_valid && voice) |=> (out_voice && out_vid == $past(s.vid)))
    else $error("voice frame not placed on voice VLAN");
  AST_GLOBAL_OFF: assert property (
    (in_valid && !s.glb_en) |=> (!out_voice && out_vid == $past(in_vid)))
    else $error("frame classified while feature disabled");
  AST_VID_RANGE: assert property (
    s.vid != 12'h000)
    else $error("voice VLAN identifier left range");
  AST_CONFLICT: assert property (
    (s.vid == s.mgmt_vid || s.vid == s.multicast_registration_vlan_id) |=> vid_conflict)
    else $error("identifier clash not flagged");
  AST_AGING_RANGE: assert property (
    s.aging >= `VVC_AGING_MIN && s.aging <= `VVC_AGING_MAX)
    else $error("aging time out of range");
  AST_REWRITE: assert property (
    (in_valid && voice && s.rw_en && mode == vvc_pkg::VVC_COS_FOLLOW)
    |=> out_pcp == $past(s.prio))
    else $error("voice priority not rewritten");
  AST_KEEP_PCP: assert property (
    (in_valid && voice && mode == vvc_pkg::VVC_COS_KEEP)
    |=> out_pcp == $past(in_pcp))
    else $error("priority changed in keep mode");
  AST_PORT_OFF: assert property (
    (in_valid && !s.port_en[in_port]) |=> !out_voice)
    else $error("frame classified on disabled port");
  AST_MEMBER: assert property (
    (in_valid && voice) |=> voice_member[$past(in_port)])
    else $error("port not refreshed by voice frame");
  AST_AGE_DEC: assert property (
    (tick && s.age_cnt[0] == 17'h00001 && !(in_valid && in_port == 3'h0))
    |=> !voice_member[0])
    else $error("port not removed after aging");
  AST_VID_READ: assert property (
    (s_axi_arvalid && s.arready && s_axi_araddr == `VVC_REG_VID && !s.glb_en)
    |=> (s_axi_rvalid && s_axi_rdata == 32'h0000_0000))
    else $error("identifier readable while disabled");
  AST_BRESP_HOLD: assert property (
    (s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp)))
    else $error("write response dropped before taken");

  COV_VOICE: cover property (in_valid && voice && do_rw);
  COV_AGEOUT: cover property (s.member[0] ##1 !s.member[0]);
  COV_CONFLICT: cover property (!vid_conflict ##1 vid_conflict);
  COV_WRITE: cover property (s_axi_bvalid && s_axi_bready);
endmodule
`default_nettype wire

// ===== testbench/vvc_frame_src.sv
// Frame header source standing in for the switch ports
`timescale 1ns/1ps
`default_nettype none
module vvc_frame_src (
  // Clock
  input  wire logic        aclk,
  // Requests from the bench
  input  wire logic        req,
  input  wire logic [2:0]  req_port,
  input  wire logic [47:0] req_mac,
  input  wire logic [11:0] req_vid,
  input  wire logic [2:0]  req_pcp,
  // Header towards the classifier
  output logic             in_valid = 1'b0,
  output logic [2:0]       in_port = 3'h0,
  output logic [47:0]      in_src_mac = 48'h0,
  output logic [11:0]      in_vid = 12'h0,
  output logic [2:0]       in_pcp = 3'h0
);
  // Data frames keep their own port VLAN beside the voice one
  always @(posedge aclk) begin
    in_valid <= req;
    if (req) begin
      in_port    <= req_port;
      in_src_mac <= req_mac;
      in_vid     <= req_vid;
      in_pcp     <= req_pcp;
    end else begin
      // Header is meaningless between frames, so it keeps moving
      in_port    <= ~in_port;
      in_src_mac <= ~in_src_mac;
      in_vid     <= ~in_vid;
      in_pcp     <= ~in_pcp;
    end
  end
endmodule
`default_nettype wire

// ===== testbench/test_vvc_classifier.sv
// Self-checking bench for the voice VLAN classifier
`timescale 1ns/1ps
`default_nettype none
`include "vvc_map.svh"
module test_vvc_classifier;
  localparam longint      MIN = 64'h14;
  localparam logic [47:0] VM  = 48'h00e0bb_123456;
  localparam logic [47:0] VM2 = 48'h0a0b0c_000001;
  localparam logic [1:0]  OK  = `VVC_RESP_OK;
  localparam logic [1:0]  ER  = `VVC_RESP_ERR;
  // ========================================
  // Signals
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        in_valid, out_valid, out_voice, vid_conflict;
  logic [2:0]  in_port, in_pcp, out_port, out_pcp;
  logic [47:0] in_src_mac;
  logic [11:0] in_vid, out_vid;
  logic [7:0]  voice_member;
  logic        req = 1'b0;
  logic [2:0]  req_port = 3'h0;
  logic [2:0]  req_pcp = 3'h0;
  logic [47:0] req_mac = 48'h0;
  logic [11:0] req_vid = 12'h0;
  int          mismatches = 0;
  int          checks = 0;
  int          cycles = 0;
  logic [7:0]  cadr [3] = '{8'h48, `VVC_REG_MGMT, `VVC_REG_MVR};

  vvc_classifier #(.MINUTE_CYCLES(MIN)) u_vvc_classifier (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .in_valid, .in_port, .in_src_mac,
    .in_vid, .in_pcp, .out_valid, .out_port, .out_vid, .out_pcp,
    .out_voice, .voice_member, .vid_conflict
  );
  vvc_frame_src u_vvc_frame_src (
    .aclk, .req, .req_port, .req_mac, .req_vid, .req_pcp, .in_valid,
    .in_port, .in_src_mac, .in_vid, .in_pcp
  );

  initial begin
    forever #4 aclk = ~aclk;
  end

  task automatic close_out();
    if (mismatches == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      close_out();
    end
  end

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ========================================
  // Bus and frame tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic ta;
    logic tw;
    ta = 1'b0;
    tw = 1'b0;
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) begin
        ta = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready === 1'b1) begin
        tw = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    chk(s_axi_bresp, er);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    chk(s_axi_rdata, ed);
    chk(s_axi_rresp, er);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic frm(input logic [2:0] p, input logic [47:0] m,
                     input logic [11:0] v, input logic [2:0] c,
                     input logic ev, input logic [11:0] eid,
                     input logic [2:0] ep);
    req      <= 1'b1;
    req_port <= p;
    req_mac  <= m;
    req_vid  <= v;
    req_pcp  <= c;
    @(posedge aclk);
    req <= 1'b0;
    repeat (2) @(posedge aclk);
    chk(out_valid, 1'b1);
    chk(out_port, p);
    chk(out_voice, ev);
    chk(out_vid, eid);
    chk(out_pcp, ep);
  endtask

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`VVC_REG_CTRL, 32'h60, OK);
    rd(`VVC_REG_VID, 32'h0, OK);
    rd(`VVC_REG_AGING, 32'h5a0, OK);
    rd(`VVC_REG_PORT_EN, 32'h0, OK);
    rd(8'h3c, 32'h0, ER);
    wr(`VVC_REG_VID, 32'h0, ER);
    wr(`VVC_REG_VID, 32'hfff, OK);
    wr(`VVC_REG_AGING, 32'h1d, ER);
    wr(`VVC_REG_AGING, 32'h10001, ER);
    wr(`VVC_REG_AGING, 32'h1e, OK);
    wr(`VVC_REG_CTRL, 32'h63, OK);
    rd(`VVC_REG_VID, 32'hfff, OK);
    rd(`VVC_REG_AGING, 32'h1e, OK);
    for (int i = 0; i < 3; i++) begin
      wr(cadr[i], 32'hfff, OK);
      chk(vid_conflict, 1'b1);
      rd(`VVC_REG_STATUS, 32'h1, OK);
      wr(cadr[i], 32'h0, OK);
      chk(vid_conflict, 1'b0);
    end
    wr(8'h80, 32'h8000e0bb, OK);
    wr(8'hc0, 32'h50686f6e, OK);
    rd(8'hc0, 32'h50686f6e, OK);
    wr(`VVC_REG_PORT_EN, 32'hbf, OK);
    frm(3'h3, VM, 12'h010, 3'h1, 1'b1, 12'hfff, 3'h6);
    frm(3'h5, VM, 12'h020, 3'h2, 1'b1, 12'hfff, 3'h6);
    frm(3'h6, VM, 12'h020, 3'h2, 1'b0, 12'h020, 3'h2);
    frm(3'h3, 48'h00e0ba_123456, 12'h030, 3'h3, 1'b0, 12'h030, 3'h3);
    frm(3'h3, 48'h112233_00e0bb, 12'h030, 3'h3, 1'b0, 12'h030, 3'h3);
    wr(`VVC_REG_COS, 32'h840, OK);
    wr(`VVC_REG_CTRL, 32'h31, OK);
    rd(`VVC_REG_COS, 32'h840, OK);
    frm(3'h3, VM, 12'h010, 3'h1, 1'b1, 12'hfff, 3'h1);
    frm(3'h5, VM, 12'h020, 3'h2, 1'b1, 12'hfff, 3'h3);
    frm(3'h0, VM, 12'h020, 3'h2, 1'b1, 12'hfff, 3'h2);
    wr(8'h80, 32'h0000e0bb, OK);
    frm(3'h3, VM, 12'h010, 3'h1, 1'b0, 12'h010, 3'h1);
    wr(8'h80, 32'h800a0b0c, OK);
    frm(3'h3, VM2, 12'h010, 3'h1, 1'b1, 12'hfff, 3'h1);
    // Second voice frame restarts the port's aging count
    repeat (300) @(posedge aclk);
    chk(voice_member[3], 1'b1);
    frm(3'h3, VM2, 12'h010, 3'h1, 1'b1, 12'hfff, 3'h1);
    repeat (400) @(posedge aclk);
    chk(voice_member[3], 1'b1);
    repeat (260) @(posedge aclk);
    chk(voice_member[3], 1'b0);
    wr(`VVC_REG_CTRL, 32'h30, OK);
    frm(3'h3, VM2, 12'h010, 3'h1, 1'b0, 12'h010, 3'h1);
    // Only byte one of the aging word is written
    s_axi_wstrb <= 4'h2;
    wr(`VVC_REG_AGING, 32'h0000_01ff, OK);
    s_axi_wstrb <= 4'hf;
    rd(`VVC_REG_AGING, 32'h11e, OK);
    rd(`VVC_REG_VID, 32'h0, OK);
    close_out();
  end
endmodule
`default_nettype wire
